// ==== hw/msc_pkg.sv ====
// Constants shared by the mode and system control block
package msc_pkg;
	localparam int unsigned MSC_ADR_W = 8;
	localparam int unsigned MSC_DAT_W = 32;
	localparam int unsigned MSC_REG_W = 8;
	localparam int unsigned MSC_MODE_W = 3;

	// Byte addresses of the word-aligned registers
	localparam logic [MSC_ADR_W-1:0] MSC_OFS_MODE_PIN_STATUS = 8'h00;
	localparam logic [MSC_ADR_W-1:0] MSC_OFS_SYSTEM_CONTROL = 8'h04;
	localparam logic [MSC_ADR_W-1:0] MSC_OFS_PORT_FUNCTION = 8'h08;
	localparam logic [1:0] MSC_ADR_ALIGN = 2'h0;

	// Mode pin status fields
	localparam int unsigned MSC_MDS_TOP_BIT = 7;
	localparam logic MSC_MDS_TOP_RST = 1'h1;
	localparam logic [MSC_MODE_W-1:0] MSC_LVL_RST = 3'h0;
	localparam logic [3:0] MSC_MDS_RSVD = 4'h0;

	// The only supported operating mode: all pins high
	localparam logic [MSC_MODE_W-1:0] MSC_MODE_SEVEN = 3'h7;

	// System control fields
	localparam int unsigned MSC_SYS_MAC_SATURATE_SELECT_BIT = 7;
	localparam int unsigned MSC_SYS_INTM_HI = 5;
	localparam int unsigned MSC_SYS_INTM_LO = 4;
	localparam int unsigned MSC_SYS_NMI_EDGE_SELECT_BIT = 3;
	localparam int unsigned MSC_SYS_ONCHIP_RAM_ENABLE_BIT = 0;
	localparam logic MSC_MAC_SATURATE_SELECT_RST = 1'h0;
	localparam logic MSC_NMI_EDGE_SELECT_RST = 1'h0;
	localparam logic MSC_ONCHIP_RAM_ENABLE_RST = 1'h1;
	localparam logic MSC_ZERO_BIT = 1'h0;

	// Interrupt control mode codes
	localparam logic [1:0] MSC_INTM_MODE0 = 2'h0;
	localparam logic [1:0] MSC_INTM_MODE2 = 2'h2;

	// Port F bit seven function: 0 plain I/O port, 1 control or clock
	localparam int unsigned MSC_PF7_ALT_BIT = 0;
	localparam logic MSC_PF7_ALT_RST = 1'h0;

	localparam logic [MSC_DAT_W-1:0] MSC_DAT_ZERO = 32'h0000_0000;
	localparam logic [MSC_REG_W-1:0] MSC_BYTE_ZERO = 8'h00;
endpackage

// ==== hw/msc_pin_if.sv ====
// Synchronised mode pin levels passed from the pin synchroniser to the core
`timescale 1ns/1ps
interface msc_pin_if;
	logic [2:0] level;

	modport sync (output level);
	modport core (input level);
endinterface

// ==== hw/msc_pin_sync.sv ====
// Three-stage synchroniser for the mode select pins
`timescale 1ns/1ps
module msc_pin_sync
	import msc_pkg::*;
(
	input wire logic mclk_i, // System clock
	input wire logic reset_i, // Synchronous reset, active high
	input wire logic [MSC_MODE_W-1:0] pins_i, // Raw mode select pins
	msc_pin_if.sync pin_bus // Filtered pin levels
);
	logic [MSC_MODE_W-1:0] s1_ff;
	logic [MSC_MODE_W-1:0] s2_ff;
	logic [MSC_MODE_W-1:0] s3_ff;
	logic [MSC_MODE_W-1:0] lvl_ff;
	logic [MSC_MODE_W-1:0] nxt_s1;
	logic [MSC_MODE_W-1:0] nxt_s2;
	logic [MSC_MODE_W-1:0] nxt_s3;
	logic [MSC_MODE_W-1:0] nxt_lvl;

	// The board straps are static, so a few cycles of latency cost nothing
	always_comb begin
		nxt_s1 = pins_i;
		nxt_s2 = s1_ff;
		nxt_s3 = s2_ff;
		nxt_lvl = lvl_ff;
		if (s2_ff == s3_ff) begin
			nxt_lvl = s3_ff;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			s1_ff <= MSC_LVL_RST;
			s2_ff <= MSC_LVL_RST;
			s3_ff <= MSC_LVL_RST;
			lvl_ff <= MSC_LVL_RST;
		end else begin
			s1_ff <= nxt_s1;
			s2_ff <= nxt_s2;
			s3_ff <= nxt_s3;
			lvl_ff <= nxt_lvl;
		end
	end

	assign pin_bus.level = lvl_ff;
endmodule

// ==== hw/msc_top.sv ====
// Mode pin status and system control registers behind a Wishbone slave
`timescale 1ns/1ps
module msc_top
	import msc_pkg::*;
(
	input wire logic mclk_i, // System clock, 250 MHz
	input wire logic reset_i, // Synchronous reset, active high
	input wire logic wb_cyc_i, // Wishbone cycle
	input wire logic wb_stb_i, // Wishbone strobe
	input wire logic wb_we_i, // Wishbone write enable
	input wire logic [MSC_ADR_W-1:0] wb_adr_i, // Wishbone byte address
	input wire logic [3:0] wb_sel_i, // Wishbone byte selects
	input wire logic [MSC_DAT_W-1:0] wb_dat_i, // Wishbone write data
	output logic [MSC_DAT_W-1:0] wb_dat_o, // Wishbone read data
	output logic wb_ack_o, // Wishbone acknowledge
	input wire logic mode_select_pin_2_i, // Mode strap pin 2
	input wire logic mode_select_pin_1_i, // Mode strap pin 1
	input wire logic mode_select_pin_0_i, // Mode strap pin 0
	output logic mode_ok_o, // Straps select the supported mode
	output logic mac_saturate_select_o, // Saturating multiply-accumulate
	output logic [1:0] irq_ctrl_mode_o, // Interrupt control mode code
	output logic nmi_edge_select_o, // NMI edge: 1 rising, 0 falling
	output logic onchip_ram_enable_o, // On-chip RAM enable
	output logic onchip_rom_enable_o, // On-chip ROM enable
	output logic ext_addr_enable_o, // External address accesses allowed
	output logic ports_io_enable_o, // All ports usable as general I/O
	output logic port_f_bit_seven_alt_o // Port F bit seven carries control or clock
);
	msc_pin_if pin_bus ();

	msc_pin_sync u_sync (
		.mclk_i(mclk_i),
		.reset_i(reset_i),
		.pins_i({mode_select_pin_2_i, mode_select_pin_1_i, mode_select_pin_0_i}),
		.pin_bus(pin_bus)
	);

	function automatic logic adr_hit(input logic [MSC_ADR_W-1:0] adr,
		input logic [MSC_ADR_W-1:0] ofs);
		adr_hit = (adr[MSC_ADR_W-1:2] == ofs[MSC_ADR_W-1:2]) && (adr[1:0] == MSC_ADR_ALIGN);
	endfunction

	logic ack_ff;
	logic [MSC_DAT_W-1:0] dat_ff;
	logic mds_top_ff;
	logic [MSC_MODE_W-1:0] mds_lvl_ff;
	logic mac_saturate_select_ff;
	logic [1:0] intm_ff;
	logic nmi_edge_select_ff;
	logic onchip_ram_enable_ff;
	logic pf7_alt_ff;
	logic mode_ok_ff;
	logic rom_en_ff;
	logic ext_en_ff;
	logic ports_io_ff;
	logic nxt_ack;
	logic [MSC_DAT_W-1:0] nxt_dat;
	logic nxt_mds_top;
	logic [MSC_MODE_W-1:0] nxt_mds_lvl;
	logic nxt_mac_saturate_select;
	logic [1:0] nxt_intm;
	logic nxt_nmi_edge_select;
	logic nxt_onchip_ram_enable;
	logic nxt_pf7_alt;
	logic nxt_mode_ok;
	logic access;
	logic decode;
	logic commit;
	logic [MSC_REG_W-1:0] wr_byte;
	logic [MSC_REG_W-1:0] sys_rd;

	assign access = wb_cyc_i && wb_stb_i;
	// Decode on the first cycle and ack on the next; writes land on the edge where ack is seen
	assign decode = access && !ack_ff;
	assign commit = access && ack_ff && wb_we_i && wb_sel_i[0];
	assign wr_byte = wb_dat_i[MSC_REG_W-1:0];

	always_comb begin
		sys_rd = MSC_BYTE_ZERO;
		sys_rd[MSC_SYS_MAC_SATURATE_SELECT_BIT] = mac_saturate_select_ff;
		sys_rd[MSC_SYS_INTM_HI:MSC_SYS_INTM_LO] = intm_ff;
		sys_rd[MSC_SYS_NMI_EDGE_SELECT_BIT] = nmi_edge_select_ff;
		sys_rd[MSC_SYS_ONCHIP_RAM_ENABLE_BIT] = onchip_ram_enable_ff;
	end

	always_comb begin
		nxt_ack = decode;
		nxt_dat = dat_ff;
		nxt_mds_top = mds_top_ff;
		nxt_mds_lvl = mds_lvl_ff;
		nxt_mac_saturate_select = mac_saturate_select_ff;
		nxt_intm = intm_ff;
		nxt_nmi_edge_select = nmi_edge_select_ff;
		nxt_onchip_ram_enable = onchip_ram_enable_ff;
		nxt_pf7_alt = pf7_alt_ff;
		nxt_mode_ok = (pin_bus.level == MSC_MODE_SEVEN);
		if (decode) begin
			nxt_dat = MSC_DAT_ZERO;
			if (!wb_we_i && adr_hit(wb_adr_i, MSC_OFS_MODE_PIN_STATUS)) begin
				// Read latches the pins; the reply carries the fresh capture
				nxt_mds_lvl = pin_bus.level;
				nxt_dat[MSC_REG_W-1:0] = {mds_top_ff, MSC_MDS_RSVD, pin_bus.level};
			end else if (!wb_we_i && adr_hit(wb_adr_i, MSC_OFS_SYSTEM_CONTROL)) begin
				nxt_dat[MSC_REG_W-1:0] = sys_rd;
			end else if (!wb_we_i && adr_hit(wb_adr_i, MSC_OFS_PORT_FUNCTION)) begin
				nxt_dat[MSC_PF7_ALT_BIT] = pf7_alt_ff;
			end
		end
		if (commit) begin
			if (adr_hit(wb_adr_i, MSC_OFS_MODE_PIN_STATUS)) begin
				nxt_mds_top = wr_byte[MSC_MDS_TOP_BIT];
			end else if (adr_hit(wb_adr_i, MSC_OFS_SYSTEM_CONTROL)) begin
				nxt_mac_saturate_select = wr_byte[MSC_SYS_MAC_SATURATE_SELECT_BIT];
				nxt_nmi_edge_select = wr_byte[MSC_SYS_NMI_EDGE_SELECT_BIT];
				nxt_onchip_ram_enable = wr_byte[MSC_SYS_ONCHIP_RAM_ENABLE_BIT];
				// A prohibited code would leave the interrupt controller undefined
				if (wr_byte[MSC_SYS_INTM_HI:MSC_SYS_INTM_LO] == MSC_INTM_MODE0 ||
					wr_byte[MSC_SYS_INTM_HI:MSC_SYS_INTM_LO] == MSC_INTM_MODE2) begin
					nxt_intm = wr_byte[MSC_SYS_INTM_HI:MSC_SYS_INTM_LO];
				end
			end else if (adr_hit(wb_adr_i, MSC_OFS_PORT_FUNCTION)) begin
				nxt_pf7_alt = wr_byte[MSC_PF7_ALT_BIT];
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			ack_ff <= 1'b0;
			dat_ff <= MSC_DAT_ZERO;
			mds_top_ff <= MSC_MDS_TOP_RST;
			mds_lvl_ff <= MSC_LVL_RST;
			mac_saturate_select_ff <= MSC_MAC_SATURATE_SELECT_RST;
			intm_ff <= MSC_INTM_MODE0;
			nmi_edge_select_ff <= MSC_NMI_EDGE_SELECT_RST;
			onchip_ram_enable_ff <= MSC_ONCHIP_RAM_ENABLE_RST;
			pf7_alt_ff <= MSC_PF7_ALT_RST;
			mode_ok_ff <= 1'b0;
			rom_en_ff <= 1'b0;
			ext_en_ff <= 1'b0;
			ports_io_ff <= 1'b0;
		end else begin
			ack_ff <= nxt_ack;
			dat_ff <= nxt_dat;
			mds_top_ff <= nxt_mds_top;
			mds_lvl_ff <= nxt_mds_lvl;
			mac_saturate_select_ff <= nxt_mac_saturate_select;
			intm_ff <= nxt_intm;
			nmi_edge_select_ff <= nxt_nmi_edge_select;
			onchip_ram_enable_ff <= nxt_onchip_ram_enable;
			pf7_alt_ff <= nxt_pf7_alt;
			mode_ok_ff <= nxt_mode_ok;
			// Single-chip mode: ROM on, no external bus, every port is I/O
			rom_en_ff <= 1'b1;
			ext_en_ff <= 1'b0;
			ports_io_ff <= 1'b1;
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = dat_ff;
	assign mode_ok_o = mode_ok_ff;
	assign mac_saturate_select_o = mac_saturate_select_ff;
	assign irq_ctrl_mode_o = intm_ff;
	assign nmi_edge_select_o = nmi_edge_select_ff;
	assign onchip_ram_enable_o = onchip_ram_enable_ff;
	assign onchip_rom_enable_o = rom_en_ff;
	assign ext_addr_enable_o = ext_en_ff;
	assign ports_io_enable_o = ports_io_ff;
	assign port_f_bit_seven_alt_o = pf7_alt_ff;

	// Checks
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (reset_i);

	logic rd_mds;
	logic rd_sys;
	logic wr_sys;
	assign rd_mds = decode && !wb_we_i && adr_hit(wb_adr_i, MSC_OFS_MODE_PIN_STATUS);
	assign rd_sys = decode && !wb_we_i && adr_hit(wb_adr_i, MSC_OFS_SYSTEM_CONTROL);
	assign wr_sys = commit && adr_hit(wb_adr_i, MSC_OFS_SYSTEM_CONTROL);

	AST_MODE_OK: assert property ((pin_bus.level == MSC_MODE_SEVEN) |=> mode_ok_o)
		else $error("mode flag not raised for all-high straps");
	AST_MODE_BAD: assert property ((pin_bus.level != MSC_MODE_SEVEN) |=> !mode_ok_o)
		else $error("mode flag raised for unsupported straps");
	AST_MDS_TOP: assert property ((commit && adr_hit(wb_adr_i, MSC_OFS_MODE_PIN_STATUS))
		|=> mds_top_ff == $past(wb_dat_i[MSC_MDS_TOP_BIT]))
		else $error("mode status top bit did not take written value");
	AST_MDS_READ: assert property (rd_mds |=> wb_ack_o && wb_dat_o[6:3] == MSC_MDS_RSVD
		&& wb_dat_o[MSC_MDS_TOP_BIT] == mds_top_ff)
		else $error("mode status reserved bits not zero");
	AST_MDS_LATCH: assert property (rd_mds |=> mds_lvl_ff == $past(pin_bus.level)
		&& wb_dat_o[2:0] == $past(pin_bus.level))
		else $error("pin levels not latched on read");
	AST_MDS_HOLD: assert property (!rd_mds |=> $stable(mds_lvl_ff))
		else $error("latched pin levels changed without a read");
	AST_LVL_RESET: assert property ($fell(reset_i) |-> mds_lvl_ff == MSC_LVL_RST
		&& onchip_ram_enable_o && !mac_saturate_select_o)
		else $error("reset values wrong after release");
	AST_MAC_SATURATE_SELECT_WR: assert property (wr_sys |=> mac_saturate_select_o ==
		$past(wb_dat_i[MSC_SYS_MAC_SATURATE_SELECT_BIT]))
		else $error("saturation select not written");
	AST_SYS_ZERO: assert property (rd_sys |=> wb_dat_o[6] == MSC_ZERO_BIT
		&& wb_dat_o[2:1] == 2'h0)
		else $error("system control reserved bits not zero");
	AST_INTM_LEGAL: assert property (irq_ctrl_mode_o[0] == MSC_ZERO_BIT)
		else $error("prohibited interrupt control mode held");
	AST_NMI_RAM_WR: assert property (wr_sys |=> nmi_edge_select_o ==
		$past(wb_dat_i[MSC_SYS_NMI_EDGE_SELECT_BIT]) && onchip_ram_enable_o ==
		$past(wb_dat_i[MSC_SYS_ONCHIP_RAM_ENABLE_BIT]))
		else $error("edge select or RAM enable not written");
	// Guarded by the previous reset level: these flops still hold reset values one edge after release
	AST_SINGLE_CHIP: assert property (!$past(reset_i) |-> onchip_rom_enable_o
		&& !ext_addr_enable_o && ports_io_enable_o)
		else $error("single-chip outputs wrong");
	AST_INTM_WR: assert property ((wr_sys && !wb_dat_i[MSC_SYS_INTM_LO]) |=>
		irq_ctrl_mode_o == $past(wb_dat_i[MSC_SYS_INTM_HI:MSC_SYS_INTM_LO]))
		else $error("legal interrupt control mode not written");
	AST_INTM_KEEP: assert property ((wr_sys && wb_dat_i[MSC_SYS_INTM_LO]) |=>
		$stable(irq_ctrl_mode_o))
		else $error("prohibited interrupt control mode changed the field");
	AST_MDS_RO: assert property ((commit && adr_hit(wb_adr_i, MSC_OFS_MODE_PIN_STATUS))
		|=> $stable(mds_lvl_ff))
		else $error("write altered the latched pin levels");
	AST_PF7_WR: assert property ((commit && adr_hit(wb_adr_i, MSC_OFS_PORT_FUNCTION))
		|=> port_f_bit_seven_alt_o == $past(wb_dat_i[MSC_PF7_ALT_BIT]))
		else $error("port F bit seven function not written");
	AST_UPPER_ZERO: assert property (wb_ack_o |-> wb_dat_o[MSC_DAT_W-1:MSC_REG_W] == '0)
		else $error("read data upper bits not zero");
	AST_ACK_LATENCY: assert property (decode |=> wb_ack_o)
		else $error("request not acknowledged in the next cycle");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

	COV_READ_MDS: cover property (rd_mds ##1 wb_ack_o);
	COV_WRITE_SYS: cover property (wr_sys ##1 mac_saturate_select_o);
	COV_BAD_INTM: cover property (wr_sys && wb_dat_i[MSC_SYS_INTM_LO]);
	COV_MODE_OK: cover property (mode_ok_o);
endmodule

// ==== verif/msc_strap_model.sv ====
// Board strapping model for the three mode select pins
`timescale 1ns/1ps
module msc_strap_model (
	input wire logic [2:0] strap_i, // Levels the board applies
	output logic mode_select_pin_2_o, // Strap pin 2
	output logic mode_select_pin_1_o, // Strap pin 1
	output logic mode_select_pin_0_o // Strap pin 0
);
	// Straps are plain wiring held high; the bench moves them only in one fault case
	assign {mode_select_pin_2_o, mode_select_pin_1_o, mode_select_pin_0_o} = strap_i;
endmodule

// ==== verif/tb_mode_and_system_control.sv ====
// Self-checking bench for the mode and system control block
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
	$display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module tb_mode_and_system_control;
	import msc_pkg::*;
	logic mclk_i = 1'b0;
	logic reset_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0000_0000;
	logic [2:0] strap = 3'h7;
	logic [31:0] wb_dat_o;
	logic wb_ack_o, mode_ok_o, mac_saturate_select_o, nmi_edge_select_o, onchip_ram_enable_o;
	logic onchip_rom_enable_o, ext_addr_enable_o, ports_io_enable_o, port_f_bit_seven_alt_o;
	logic [1:0] irq_ctrl_mode_o;
	logic p2, p1, p0;
	int error_cnt = 0;
	int n_compared = 0;
	int cycles = 0;
	logic [31:0] seed = 32'h8E50;
	logic [31:0] expq[$];
	logic [7:0] sys_exp;
	logic [1:0] im;
	logic [31:0] exp_rd;

	always #2 mclk_i = ~mclk_i;

	msc_strap_model u_strap (.strap_i(strap), .mode_select_pin_2_o(p2),
		.mode_select_pin_1_o(p1), .mode_select_pin_0_o(p0));

	msc_top u_dut (.mclk_i(mclk_i), .reset_i(reset_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .mode_select_pin_2_i(p2), .mode_select_pin_1_i(p1),
		.mode_select_pin_0_i(p0), .mode_ok_o(mode_ok_o),
		.mac_saturate_select_o(mac_saturate_select_o), .irq_ctrl_mode_o(irq_ctrl_mode_o),
		.nmi_edge_select_o(nmi_edge_select_o), .onchip_ram_enable_o(onchip_ram_enable_o),
		.onchip_rom_enable_o(onchip_rom_enable_o), .ext_addr_enable_o(ext_addr_enable_o),
		.ports_io_enable_o(ports_io_enable_o), .port_f_bit_seven_alt_o(port_f_bit_seven_alt_o));

	function automatic logic [31:0] xs(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		return y ^ (y << 5);
	endfunction

	task automatic report_and_stop();
		if (error_cnt == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Holds the request until ack is seen; the bench timeout is the only limit
	task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [3:0] s,
		input logic [7:0] d);
		@(posedge mclk_i);
		{cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, s, 24'h000000, d};
		do begin
			@(posedge mclk_i);
		end while (wb_ack_o !== 1'b1);
		{cyc, stb} <= 2'b00;
	endtask

	task automatic wb_read(input logic [7:0] a, input logic [7:0] e);
		expq.push_back({24'h000000, e});
		wb_cycle(1'b0, a, 4'hF, 8'h00);
	endtask

	task automatic sys_check();
		@(posedge mclk_i);
		`CHK(mac_saturate_select_o, sys_exp[7])
		`CHK(irq_ctrl_mode_o, sys_exp[5:4])
		`CHK(nmi_edge_select_o, sys_exp[3])
		`CHK(onchip_ram_enable_o, sys_exp[0])
		wb_read(MSC_OFS_SYSTEM_CONTROL, sys_exp);
	endtask

	// Read results are judged here, oldest expectation first
	always @(posedge mclk_i) begin
		cycles++;
		if (cycles > 20000) begin
			error_cnt++;
			report_and_stop();
		end else if (wb_ack_o === 1'b1 && cyc && !we) begin
			// Pop once: the compare macro names its expected value twice
			exp_rd = expq.pop_front();
			`CHK(wb_dat_o, exp_rd)
		end
	end

	initial begin
		sys_exp = 8'h01;
		repeat (20) @(posedge mclk_i);
		reset_i <= 1'b0;
		repeat (8) @(posedge mclk_i);
		`CHK(mode_ok_o, 1'b1)
		`CHK({onchip_rom_enable_o, ext_addr_enable_o}, 2'b10)
		`CHK(u_dut.mds_lvl_ff, MSC_LVL_RST)
		`CHK({ports_io_enable_o, port_f_bit_seven_alt_o}, 2'b10)
		sys_check();
		wb_read(MSC_OFS_MODE_PIN_STATUS, 8'h87);
		wb_cycle(1'b1, MSC_OFS_MODE_PIN_STATUS, 4'h1, 8'h78);
		wb_read(MSC_OFS_MODE_PIN_STATUS, 8'h07);
		wb_cycle(1'b1, MSC_OFS_MODE_PIN_STATUS, 4'h1, 8'hFF);
		wb_read(MSC_OFS_MODE_PIN_STATUS, 8'h87);
		for (int i = 0; i < 24; i++) begin
			seed = xs(seed);
			im = (i < 4) ? i[1:0] : seed[5:4];
			wb_cycle(1'b1, MSC_OFS_SYSTEM_CONTROL, 4'h1, {seed[7:6], im, seed[3:0]});
			if (im[0] == 1'b0) begin
				sys_exp[5:4] = im;
			end
			sys_exp = {seed[7], 1'b0, sys_exp[5:4], seed[3], 2'b00, seed[0]};
			sys_check();
		end
		// Deliberate strap fault: pins moved away from the supported mode
		strap <= 3'h5;
		repeat (10) @(posedge mclk_i);
		`CHK(mode_ok_o, 1'b0)
		wb_read(MSC_OFS_MODE_PIN_STATUS, 8'h85);
		strap <= 3'h7;
		repeat (10) @(posedge mclk_i);
		`CHK(mode_ok_o, 1'b1)
		wb_read(MSC_OFS_MODE_PIN_STATUS, 8'h87);
		wb_cycle(1'b1, MSC_OFS_PORT_FUNCTION, 4'h1, 8'h01);
		@(posedge mclk_i);
		`CHK(port_f_bit_seven_alt_o, 1'b1)
		wb_read(8'h10, 8'h00);
		wb_cycle(1'b1, 8'h05, 4'h1, 8'h00);
		wb_cycle(1'b1, MSC_OFS_SYSTEM_CONTROL, 4'h0, 8'h00);
		sys_check();
		@(posedge mclk_i);
		reset_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		reset_i <= 1'b0;
		sys_exp = 8'h01;
		repeat (8) @(posedge mclk_i);
		`CHK(port_f_bit_seven_alt_o, 1'b0)
		`CHK(u_dut.mds_lvl_ff, MSC_LVL_RST)
		`CHK({onchip_rom_enable_o, ext_addr_enable_o, ports_io_enable_o}, 3'b101)
		sys_check();
		wb_read(MSC_OFS_MODE_PIN_STATUS, 8'h87);
		repeat (2) @(posedge mclk_i);
		report_and_stop();
	end
endmodule
